// >>> src/flash_cfg_consts.svh
// Constant definitions for the flash configuration and access block
`ifndef FLASH_CFG_CONSTS_SVH
`define FLASH_CFG_CONSTS_SVH

// ============================================================
// Configuration page layout
`define CFG_TUNING_OFS 9'h000
`define CFG_TUNING_LEN 9'h020
`define CFG_UNPROTECTED_PAGE_COUNT_OFS 9'h020
`define CFG_RSVD0_OFS 9'h021
`define CFG_RDIS_OFS 9'h023
`define CFG_DEBUG_OFS 9'h024
`define CFG_RSVD1_OFS 9'h025
`define CFG_USER_OFS 9'h100
`define CFG_ERASED 8'hff
`define CFG_RDIS_SET 8'h00

// ============================================================
// Memory map
`define CODE_PAGES 6'h20
`define NV_PAGE_FIRST 6'h20
`define NV_PAGE_LAST 6'h23
`define MCU_NV_BASE 16'hfa00
`define SPI_NV_BASE 16'h4400
`define SPI_NV_END 16'h47ff
`define SPI_CODE_END 16'h3fff
`define NV_BYTES 1536
`define NV_P33_IDX 11'h100
`define NV_P34_IDX 11'h200
`define NV_P35_IDX 11'h400
`define SPI_NV_IDX_OFS 11'h200

`endif

// >>> src/flash_cfg_pkg.sv
// Types for the flash configuration and access block
package flash_cfg_pkg;
    typedef enum logic [4:0] {
        BOOT_UNPROTECTED_PAGE_COUNT = 5'b00001,
        BOOT_RDIS = 5'b00010,
        BOOT_DBG = 5'b00100,
        BOOT_LAST = 5'b01000,
        BOOT_RUN = 5'b10000
    } boot_state_t;
endpackage

// >>> src/nv_addr_map.sv
// Address decoder from microcontroller or SPI address to NV data byte index and page
`include "flash_cfg_consts.svh"
module nv_addr_map #(
    parameter bit SPI_SIDE = 1'b0
) (
    input wire logic [15:0] addr_i,
    output logic hit_o,
    output logic [10:0] index_o,
    output logic [5:0] page_o
);
    logic [15:0] rel;

    always_comb begin
        if (SPI_SIDE) begin
            // Only the two normal pages are reachable from SPI
            rel = addr_i - `SPI_NV_BASE;
            hit_o = (addr_i >= `SPI_NV_BASE) && (addr_i <= `SPI_NV_END); // RULE2
            index_o = rel[10:0] + `SPI_NV_IDX_OFS;
        end else begin
            rel = addr_i - `MCU_NV_BASE;
            hit_o = (addr_i >= `MCU_NV_BASE); // RULE2
            index_o = rel[10:0];
        end
        if (index_o < `NV_P33_IDX) begin
            page_o = `NV_PAGE_FIRST;
        end else if (index_o < `NV_P34_IDX) begin
            page_o = `NV_PAGE_FIRST + 6'h01;
        end else if (index_o < `NV_P35_IDX) begin
            page_o = `NV_PAGE_FIRST + 6'h02;
        end else begin
            page_o = `NV_PAGE_LAST;
        end
    end
endmodule

// >>> src/flash_cfg_ctrl.sv
// Flash configuration loader and access control for microcontroller and SPI host
//
// Notes on behaviour
// RULE1 - Two 256-byte and two 512-byte NV pages
// RULE2 - NV pages mapped at 0xFA00 up; SPI at 0x4400
// RULE3 - NV pages erased as page numbers 32 to 35
// RULE4 - Software clears write select before NV writes
// RULE5 - NV data sits in external data space
// RULE6 - Each NV byte written once per erase
// RULE7 - Main block 16 kB code, 1.5 kB data
// RULE8 - Configuration page loaded at every reset
// RULE9 - Host changes configuration only over SPI
// RULE10 - Host leaves first 32 tuning bytes alone
// RULE11 - Offset 0x20 loads protection; 0xFF unprotects
// RULE12 - Host keeps reserved bytes at 0xFF
// RULE13 - Readback disable blocks main block, allows config reads
// RULE14 - Readback disable set once, cleared by erase-all
// RULE15 - Debug byte erased disables debug, else enables
// RULE16 - Tuning area altered by erase or selected program
// RULE17 - Host saves tuning area around erase-all
// RULE18 - Count below 32 protects pages from there up
// RULE19 - Microcontroller held in reset until configuration loaded
`include "flash_cfg_consts.svh"
module flash_cfg_ctrl
    import flash_cfg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Configuration page read port, data valid one cycle after enable
    output logic cfg_rd_en_o,
    output logic [8:0] cfg_rd_addr_o,
    input wire logic [7:0] cfg_rd_data_i,
    output logic cfg_wr_o,
    output logic [8:0] cfg_wr_addr_o,
    output logic [7:0] cfg_wr_data_o,
    // Loaded configuration
    output logic boot_done_o,
    output logic mcu_rst_o,
    output logic [7:0] page_protection_register_o,
    output logic readback_disabled_o,
    output logic debug_enable_o,
    // Microcontroller requests
    input wire logic program_memory_write_select_i,
    input wire logic mcu_rd_i,
    input wire logic mcu_wr_i,
    input wire logic [15:0] mcu_addr_i,
    input wire logic mcu_code_wr_i,
    input wire logic [13:0] mcu_code_addr_i,
    input wire logic mcu_erase_i,
    input wire logic [5:0] mcu_erase_page_i,
    output logic mcu_grant_o,
    output logic mcu_deny_o,
    output logic [10:0] mcu_nv_index_o,
    // SPI host requests
    input wire logic config_page_select_i,
    input wire logic spi_rd_i,
    input wire logic spi_wr_i,
    input wire logic [15:0] spi_addr_i,
    input wire logic spi_erase_i,
    input wire logic [5:0] spi_erase_page_i,
    input wire logic spi_erase_all_i,
    input wire logic spi_rdis_cmd_i,
    output logic spi_grant_o,
    output logic spi_deny_o,
    output logic [10:0] spi_nv_index_o,
    output logic nv_erase_o,
    output logic [5:0] nv_erase_page_o
);
    // ============================================================
    // Address decode
    boot_state_t state;
    logic [7:0] unprotected_page_count;
    logic [7:0] rdis_byte;
    logic [7:0] dbg_byte;
    logic [`NV_BYTES-1:0] written;
    logic m_hit;
    logic s_hit;
    logic [10:0] m_idx;
    logic [10:0] s_idx;
    logic [5:0] m_page;
    logic [5:0] s_page;
    logic run;
    logic rdis;

    nv_addr_map #(.SPI_SIDE(1'b0)) u_mcu_map (
        .addr_i(mcu_addr_i),
        .hit_o(m_hit),
        .index_o(m_idx),
        .page_o(m_page)
    );

    nv_addr_map #(.SPI_SIDE(1'b1)) u_spi_map (
        .addr_i(spi_addr_i),
        .hit_o(s_hit),
        .index_o(s_idx),
        .page_o(s_page)
    );

    // Requests wait for the released core, not just the last boot state
    assign run = boot_done_o;
    assign rdis = (rdis_byte != `CFG_ERASED);

    // ============================================================
    // Boot loader
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= BOOT_UNPROTECTED_PAGE_COUNT;
            cfg_rd_en_o <= 1'b0;
            cfg_rd_addr_o <= `CFG_UNPROTECTED_PAGE_COUNT_OFS;
        end else begin
            case (state)
                BOOT_UNPROTECTED_PAGE_COUNT: begin
                    cfg_rd_en_o <= 1'b1;
                    cfg_rd_addr_o <= `CFG_UNPROTECTED_PAGE_COUNT_OFS;
                    state <= BOOT_RDIS;
                end
                BOOT_RDIS: begin
                    cfg_rd_addr_o <= `CFG_RDIS_OFS;
                    state <= BOOT_DBG;
                end
                BOOT_DBG: begin
                    cfg_rd_addr_o <= `CFG_DEBUG_OFS;
                    state <= BOOT_LAST;
                end
                BOOT_LAST: begin
                    cfg_rd_en_o <= 1'b0;
                    state <= BOOT_RUN;
                end
                BOOT_RUN: begin
                    cfg_rd_en_o <= 1'b0;
                end
                default: begin
                    state <= BOOT_UNPROTECTED_PAGE_COUNT;
                end
            endcase
        end
    end

    // Release the core only once every byte has landed
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mcu_rst_o <= 1'b1;
            boot_done_o <= 1'b0;
        end else begin
            mcu_rst_o <= (state != BOOT_RUN); // RULE19
            boot_done_o <= (state == BOOT_RUN);
        end
    end

    // ============================================================
    // Access decisions
    logic m_req;
    logic m_ok;
    logic m_set;
    logic m_nv_erase;
    logic s_req;
    logic s_ok;
    logic s_set;
    logic s_nv_erase;
    logic s_rdis_ok;
    logic s_erase_all_ok;

    function automatic logic protected_page(input logic [7:0] ppr, input logic [5:0] pg);
        protected_page = (ppr < {2'b00, `CODE_PAGES}) && ({2'b00, pg} >= ppr); // RULE18
    endfunction

    always_comb begin
        m_req = mcu_rd_i | mcu_wr_i | mcu_code_wr_i | mcu_erase_i;
        m_ok = 1'b0;
        m_set = 1'b0;
        m_nv_erase = 1'b0;
        if (mcu_rd_i) begin
            m_ok = m_hit; // RULE5
        end else if (mcu_wr_i) begin
            // Write select must be clear; SPI wins a same-cycle collision
            m_ok = m_hit && !program_memory_write_select_i && !written[m_idx]
                && !spi_wr_i; // RULE4 RULE6
            m_set = m_ok;
        end else if (mcu_code_wr_i) begin
            m_ok = !protected_page(page_protection_register_o, {1'b0, mcu_code_addr_i[13:9]});
        end else if (mcu_erase_i) begin
            if (mcu_erase_page_i >= `NV_PAGE_FIRST) begin
                m_ok = (mcu_erase_page_i <= `NV_PAGE_LAST); // RULE3
                m_nv_erase = m_ok;
            end else begin
                m_ok = !protected_page(page_protection_register_o, mcu_erase_page_i);
            end
        end
        if (!run) begin
            m_ok = 1'b0;
            m_set = 1'b0;
            m_nv_erase = 1'b0;
        end
    end

    always_comb begin
        s_req = spi_rd_i | spi_wr_i | spi_erase_i | spi_erase_all_i | spi_rdis_cmd_i;
        s_ok = 1'b0;
        s_set = 1'b0;
        s_nv_erase = 1'b0;
        s_rdis_ok = 1'b0;
        s_erase_all_ok = 1'b0;
        if (spi_erase_all_i) begin
            s_ok = 1'b1; // RULE14
            s_erase_all_ok = 1'b1;
        end else if (spi_rdis_cmd_i) begin
            s_ok = !rdis; // RULE14
            s_rdis_ok = s_ok;
        end else if (spi_rd_i) begin
            if (config_page_select_i) begin
                s_ok = 1'b1; // RULE13
            end else begin
                s_ok = !rdis && (s_hit || spi_addr_i <= `SPI_CODE_END); // RULE7 RULE13
            end
        end else if (spi_wr_i) begin
            // Config page programming needs the page select, tuning area included
            if (config_page_select_i) begin
                s_ok = !rdis; // RULE16
            end else if (s_hit) begin
                s_ok = !rdis && !written[s_idx]; // RULE6
                s_set = s_ok;
            end else begin
                s_ok = !rdis && (spi_addr_i <= `SPI_CODE_END);
            end
        end else if (spi_erase_i) begin
            if (config_page_select_i) begin
                s_ok = !rdis; // RULE16
            end else begin
                s_ok = !rdis && (spi_erase_page_i <= `NV_PAGE_LAST); // RULE3 RULE13
                s_nv_erase = s_ok && (spi_erase_page_i >= `NV_PAGE_FIRST);
            end
        end
        if (!run) begin
            s_ok = 1'b0;
            s_set = 1'b0;
            s_nv_erase = 1'b0;
            s_rdis_ok = 1'b0;
            s_erase_all_ok = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mcu_grant_o <= 1'b0;
            mcu_deny_o <= 1'b0;
            mcu_nv_index_o <= 11'h000;
            spi_grant_o <= 1'b0;
            spi_deny_o <= 1'b0;
            spi_nv_index_o <= 11'h000;
            nv_erase_o <= 1'b0;
            nv_erase_page_o <= 6'h00;
        end else begin
            mcu_grant_o <= m_req && m_ok;
            mcu_deny_o <= m_req && !m_ok;
            mcu_nv_index_o <= m_idx;
            spi_grant_o <= s_req && s_ok;
            spi_deny_o <= s_req && !s_ok;
            spi_nv_index_o <= s_idx;
            nv_erase_o <= s_nv_erase || m_nv_erase;
            nv_erase_page_o <= s_nv_erase ? spi_erase_page_i : mcu_erase_page_i;
        end
    end

    // ============================================================
    // Write-once tracking, one flag per NV byte
    genvar gi;
    generate
        for (gi = 0; gi < `NV_BYTES; gi++) begin : g_track
            localparam logic [10:0] IDX = 11'(gi);
            localparam logic [5:0] PG = (IDX < `NV_P33_IDX) ? 6'h20 :
                (IDX < `NV_P34_IDX) ? 6'h21 : (IDX < `NV_P35_IDX) ? 6'h22 : 6'h23;
            logic clr;
            logic set;
            assign clr = s_erase_all_ok || (s_nv_erase && spi_erase_page_i == PG)
                || (m_nv_erase && mcu_erase_page_i == PG); // RULE1 RULE3
            assign set = (s_set && s_idx == IDX) || (m_set && m_idx == IDX);
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    written[gi] <= 1'b0;
                end else if (set) begin
                    written[gi] <= 1'b1; // RULE6
                end else if (clr) begin
                    written[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ============================================================
    // Configuration registers
    // Tracking restarts empty after reset: the flash contents are not re-scanned
    logic [7:0] next_unprotected_page_count;
    logic [7:0] next_rdis_byte;
    logic [7:0] next_dbg_byte;

    // Read data lags its address by a cycle, so each byte lands one state later;
    // the outputs load from the next values so all are valid with boot done
    always_comb begin
        next_unprotected_page_count = unprotected_page_count;
        next_rdis_byte = rdis_byte;
        next_dbg_byte = dbg_byte;
        if (state == BOOT_DBG) begin
            next_unprotected_page_count = cfg_rd_data_i; // RULE8 RULE11
        end else if (state == BOOT_LAST) begin
            next_rdis_byte = cfg_rd_data_i; // RULE8
        end else if ((state == BOOT_RUN) && !boot_done_o) begin
            next_dbg_byte = cfg_rd_data_i; // RULE8
        end else if (s_erase_all_ok) begin
            next_unprotected_page_count = `CFG_ERASED;
            next_rdis_byte = `CFG_ERASED; // RULE14
            next_dbg_byte = `CFG_ERASED;
        end else if (s_rdis_ok) begin
            next_rdis_byte = `CFG_RDIS_SET; // RULE14
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            unprotected_page_count <= `CFG_ERASED;
            rdis_byte <= `CFG_ERASED;
            dbg_byte <= `CFG_ERASED;
        end else begin
            unprotected_page_count <= next_unprotected_page_count;
            rdis_byte <= next_rdis_byte;
            dbg_byte <= next_dbg_byte;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            page_protection_register_o <= `CFG_ERASED;
            readback_disabled_o <= 1'b0;
            debug_enable_o <= 1'b0;
            cfg_wr_o <= 1'b0;
            cfg_wr_addr_o <= `CFG_RDIS_OFS;
            cfg_wr_data_o <= `CFG_RDIS_SET;
        end else begin
            page_protection_register_o <= next_unprotected_page_count; // RULE11
            readback_disabled_o <= (next_rdis_byte != `CFG_ERASED); // RULE13
            debug_enable_o <= (next_dbg_byte != `CFG_ERASED); // RULE15
            cfg_wr_o <= s_rdis_ok; // RULE14
            cfg_wr_addr_o <= `CFG_RDIS_OFS;
            cfg_wr_data_o <= `CFG_RDIS_SET;
        end
    end
endmodule

// >>> verif/flash_cfg_props.sv
// Assertion checker for the flash configuration controller
module flash_cfg_props (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic cfg_rd_en_o,
    input wire logic [8:0] cfg_rd_addr_o,
    input wire logic [7:0] cfg_rd_data_i,
    input wire logic boot_done_o,
    input wire logic mcu_rst_o,
    input wire logic [7:0] page_protection_register_o,
    input wire logic readback_disabled_o,
    input wire logic debug_enable_o,
    input wire logic program_memory_write_select_i,
    input wire logic mcu_rd_i,
    input wire logic mcu_wr_i,
    input wire logic mcu_code_wr_i,
    input wire logic [13:0] mcu_code_addr_i,
    input wire logic mcu_erase_i,
    input wire logic mcu_grant_o,
    input wire logic mcu_deny_o,
    input wire logic spi_erase_all_i,
    input wire logic spi_rdis_cmd_i,
    input wire logic spi_grant_o,
    input wire logic nv_erase_o,
    input wire logic [5:0] nv_erase_page_o
);
    // ============================================================
    // Boot load and request answers
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);
    sequence s_load;
        cfg_rd_en_o && cfg_rd_addr_o == 9'h020 ##1 cfg_rd_addr_o == 9'h023
        ##1 cfg_rd_addr_o == 9'h024 ##1 !cfg_rd_en_o;
    endsequence
    sequence s_mcu_req;
        boot_done_o && (mcu_rd_i || mcu_wr_i || mcu_code_wr_i || mcu_erase_i);
    endsequence
    boot_order_a: assert property ($fell(srst_i) |=> s_load ##1 boot_done_o)
        else $error("boot read order wrong");
    core_hold_a: assert property (mcu_rst_o != boot_done_o)
        else $error("core reset not tied to load");
    unprotected_page_count_load_a: assert property ($rose(boot_done_o) |->
        page_protection_register_o == $past(cfg_rd_data_i, 3)) else $error("unprotected_page_count not loaded");
    rdis_load_a: assert property ($rose(boot_done_o) |->
        readback_disabled_o == ($past(cfg_rd_data_i, 2) != 8'hff)) else $error("rdis load");
    debug_load_a: assert property ($rose(boot_done_o) |->
        debug_enable_o == ($past(cfg_rd_data_i) != 8'hff)) else $error("debug load");
    mcu_answer_a: assert property (s_mcu_req |=> mcu_grant_o != mcu_deny_o)
        else $error("mcu answer missing");
    pmw_deny_a: assert property (boot_done_o && mcu_wr_i && !mcu_rd_i &&
        program_memory_write_select_i |=> mcu_deny_o) else $error("write with select granted");
    protect_deny_a: assert property (boot_done_o && mcu_code_wr_i && !mcu_rd_i &&
        !mcu_wr_i && page_protection_register_o < 8'h20 &&
        {3'h0, mcu_code_addr_i[13:9]} >= page_protection_register_o |=> mcu_deny_o)
        else $error("protected page written");
    rdis_once_a: assert property (boot_done_o && spi_rdis_cmd_i && !spi_erase_all_i |=>
        spi_grant_o != $past(readback_disabled_o) ##1 readback_disabled_o)
        else $error("rdis command wrong");
    erase_all_a: assert property (boot_done_o && spi_erase_all_i |=> spi_grant_o ##1
        (page_protection_register_o == 8'hff && !readback_disabled_o && !debug_enable_o))
        else $error("erase all did not restore");
    nv_page_a: assert property (nv_erase_o |-> nv_erase_page_o inside {[6'h20:6'h23]})
        else $error("nv erase page out of range");
endmodule

bind flash_cfg_ctrl flash_cfg_props u_flash_cfg_props (.*);

// >>> verif/cfg_page_model.sv
// Behavioural configuration page that answers the controller's boot reads
module cfg_page_model (
    input wire logic clk_sys_i,
    input wire logic rd_en_i,
    input wire logic [8:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    input wire logic wr_i,
    input wire logic [8:0] wr_addr_i,
    input wire logic [7:0] wr_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [512];
    initial begin
        rd_data_o = 8'h00;
        foreach (mem[i]) mem[i] = 8'hff;
        for (int i = 0; i < 32; i++) mem[i] = 8'(i * 7);
    end
    // Outside a read the port toggles, so a stale byte can never pass as data
    always @(posedge clk_sys_i) begin
        rd_data_o <= rd_en_i ? mem[rd_addr_i] : ~rd_data_o;
        if (wr_i) mem[wr_addr_i] <= wr_data_i;
    end
endmodule

// >>> verif/flash_cfg_ctrl_tb.sv
// Self-checking bench for the flash configuration controller
module flash_cfg_ctrl_tb;
    import flash_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic program_memory_write_select = 1'b0;
    logic cps = 1'b0;
    logic [3:0] mq = 4'h0;
    logic [4:0] sq = 5'h00;
    logic [15:0] ma = 16'h0000;
    logic [15:0] sa = 16'h0000;
    logic rd_en, cfg_wr, boot_done, rdis, dbg, mg, md, sg, sd, mrst, nve;
    logic [8:0] rd_addr, wr_addr;
    logic [7:0] rd_data, wr_data, ppr;
    logic [5:0] nvp;
    logic [10:0] midx, sidx;
    logic [7:0] tune [32];
    logic mq_exp[$];
    logic sq_exp[$];
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    // ============================================================
    // Design and partner
    flash_cfg_ctrl u_flash_cfg_ctrl (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .cfg_rd_en_o(rd_en), .cfg_rd_addr_o(rd_addr), .cfg_rd_data_i(rd_data),
        .cfg_wr_o(cfg_wr), .cfg_wr_addr_o(wr_addr), .cfg_wr_data_o(wr_data),
        .boot_done_o(boot_done), .mcu_rst_o(mrst), .page_protection_register_o(ppr),
        .readback_disabled_o(rdis), .debug_enable_o(dbg), .program_memory_write_select_i(program_memory_write_select),
        .mcu_rd_i(mq[0]), .mcu_wr_i(mq[1]), .mcu_addr_i(ma), .mcu_code_wr_i(mq[2]),
        .mcu_code_addr_i(ma[13:0]), .mcu_erase_i(mq[3]), .mcu_erase_page_i(ma[5:0]),
        .mcu_grant_o(mg), .mcu_deny_o(md), .mcu_nv_index_o(midx), .config_page_select_i(cps),
        .spi_rd_i(sq[0]), .spi_wr_i(sq[1]), .spi_addr_i(sa), .spi_erase_i(sq[2]),
        .spi_erase_page_i(sa[5:0]), .spi_erase_all_i(sq[3]), .spi_rdis_cmd_i(sq[4]),
        .spi_grant_o(sg), .spi_deny_o(sd), .spi_nv_index_o(sidx), .nv_erase_o(nve),
        .nv_erase_page_o(nvp));
    cfg_page_model u_cfg_page_model (.clk_sys_i(clk_sys_i), .rd_en_i(rd_en),
        .rd_addr_i(rd_addr), .rd_data_o(rd_data), .wr_i(cfg_wr), .wr_addr_i(wr_addr),
        .wr_data_i(wr_data));
    // ============================================================
    // Compare, drive and report
    task automatic chk_ans(input logic got, ref logic q[$], input string m);
        logic e;
        checked++;
        e = (q.size() > 0) ? q.pop_front() : 1'bx;
        if (got !== e) begin
            fails++;
            $display("MISMATCH at %0t: %s answer %b", $time, m, got);
        end
    endtask
    task automatic chk_cfg(input logic [7:0] got, input logic [7:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    // One-cycle request pulse; the expected answer is queued for the monitor
    task automatic req(input bit spi, input int k, input logic [15:0] a, input logic e);
        @(negedge clk_sys_i);
        if (spi) begin
            sq[k] = 1'b1;
            sa = a;
            sq_exp.push_back(e);
        end else begin
            mq[k] = 1'b1;
            ma = a;
            mq_exp.push_back(e);
        end
        @(negedge clk_sys_i);
        mq = 4'h0;
        sq = 5'h00;
    endtask
    task automatic flush(input string m);
        repeat (3) @(negedge clk_sys_i);
        chk_cfg(8'(mq_exp.size() + sq_exp.size()), 8'h00, m);
        $display("Test %s done at %0t", m, $time);
    endtask
    task automatic boot(input logic [7:0] unprotected_page_count, input logic [7:0] rb, input logic [7:0] de);
        int n;
        u_cfg_page_model.mem[9'h020] = unprotected_page_count;
        u_cfg_page_model.mem[9'h023] = rb;
        u_cfg_page_model.mem[9'h024] = de;
        @(negedge clk_sys_i);
        srst_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        srst_i = 1'b0;
        n = 0;
        while (boot_done !== 1'b1 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk_cfg({7'h00, boot_done}, 8'h01, "boot");
        chk_cfg({7'h00, mrst}, 8'h00, "core reset");
        chk_cfg(ppr, unprotected_page_count, "unprotected_page_count");
        chk_cfg({7'h00, rdis}, {7'h00, rb != 8'hff}, "rdis");
        chk_cfg({7'h00, dbg}, {7'h00, de != 8'hff}, "debug");
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(negedge clk_sys_i) begin
        if (mg || md) chk_ans(mg, mq_exp, "mcu");
        if (sg || sd) chk_ans(sg, sq_exp, "spi");
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            $display("MISMATCH at %0t: timeout", $time);
            wrap_up();
        end
    end
    // ============================================================
    // Scenarios
    initial begin
        logic [15:0] a;
        void'($urandom(45397));
        boot(8'hff, 8'hff, 8'hff);
        program_memory_write_select = 1'b1;
        req(0, 1, 16'hfb10, 1'b0);
        program_memory_write_select = 1'b0;
        req(0, 0, 16'hfa00, 1'b1);
        req(0, 0, 16'hf9ff, 1'b0);
        req(0, 1, 16'hfb10, 1'b1);
        chk_cfg(midx[10:3], 8'h22, "mcu index");
        req(0, 1, 16'hfb10, 1'b0);
        req(0, 3, 16'h0021, 1'b1);
        chk_cfg({1'b0, nve, nvp}, 8'h61, "mcu erase page");
        req(0, 1, 16'hfb10, 1'b1);
        req(0, 3, 16'h0024, 1'b0);
        for (int p = 32; p < 36; p++) begin
            req(1, 2, 16'(p), 1'b1);
            chk_cfg({1'b0, nve, nvp}, 8'(p + 64), "spi erase page");
        end
        req(1, 1, 16'h4600, 1'b1);
        chk_cfg(sidx[10:3], 8'h80, "spi index");
        req(1, 1, 16'h4600, 1'b0);
        req(1, 4, 16'h0000, 1'b1);
        req(1, 0, 16'h4400, 1'b0);
        cps = 1'b1;
        req(1, 0, 16'h0020, 1'b1);
        cps = 1'b0;
        req(1, 4, 16'h0000, 1'b0);
        flush("nv access");
        chk_cfg(u_cfg_page_model.mem[9'h023], 8'h00, "cfg write");
        boot(8'h0c, 8'h00, 8'h5a);
        req(0, 2, 16'h1600, 1'b1);
        req(0, 2, 16'h1800, 1'b0);
        for (int i = 0; i < 32; i++) tune[i] = u_cfg_page_model.mem[i];
        req(1, 3, 16'h0000, 1'b1);
        flush("protect");
        // Erase-all wipes the whole page; the host puts the tuning bytes back
        for (int i = 0; i < 512; i++) u_cfg_page_model.mem[i] = 8'hff;
        for (int i = 0; i < 32; i++) u_cfg_page_model.mem[i] = tune[i];
        chk_cfg(ppr, 8'hff, "erase all unprotected_page_count");
        chk_cfg({6'h00, rdis, dbg}, 8'h00, "erase all flags");
        req(1, 0, 16'h4400, 1'b1);
        req(0, 2, 16'h1800, 1'b1);
        flush("erase all");
        for (int i = 0; i < 3; i++) begin
            boot(8'($urandom), 8'($urandom), 8'($urandom_range(1) ? 8'hff : 8'h3c));
            a = 16'hfa00 + 16'($urandom_range(16'h05ff));
            req(0, 1, a, 1'b1);
            req(0, 1, a, 1'b0);
            flush("random");
        end
        wrap_up();
    end
endmodule
